// >>> psbac_core.sv
// Purpose: Pin-level access control of a pipelined burst SRAM
// Assumes: Controller drives all synchronous pins on clk; array is flip-flops
// Notes:   dq_oe_n gates the registered drive state with the asynchronous enable
`timescale 1ns/10ps

module psbac_core import psbac_pkg::*; (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // Synchronous controls
    input  wire logic              clock_qualify_n,
    input  wire logic              chip_select_1_n,
    input  wire logic              chip_select_2,
    input  wire logic              chip_select_3_n,
    input  wire logic              burst_step_or_load,
    input  wire logic              write_n,
    input  wire logic [LANES-1:0]  byte_lane_mask_n,
    input  wire logic [ADDR_W-1:0] addr,
    // Data pins
    input  wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe_n,
    // Asynchronous and strap pins
    input  wire logic              output_enable_n,
    input  wire logic              sleep_request,
    input  wire logic              burst_mode,
    output logic                   sleep_active,
    // Test port
    input  wire logic              test_clk,
    input  wire logic              test_mode_select,
    output psbac_tap_type          tap_state
);

    // ==========================================================
    // Declarations
    psbac_op_type        op_ff;
    psbac_op_type        nxt_op;
    psbac_op_type        s2_ff;
    logic [ADDR_W-1:0]   start_ff;
    logic [ADDR_W-1:0]   nxt_start;
    logic [BURST_W-1:0]  cnt_ff;
    logic [BURST_W-1:0]  nxt_cnt;
    logic                dir_ff;
    logic                nxt_dir;
    logic                act_ff;
    logic                nxt_act;
    logic [DATA_W-1:0]   dq_out_ff;
    logic                drive_n_ff;
    logic [DATA_W-1:0]   rd_word;
    logic                sleep_s1_ff;
    logic                sleep_ff;
    logic                mode_s1_ff;
    logic                mode_ff;
    logic                tck_s1_ff;
    logic                tck_s2_ff;
    logic                tck_s3_ff;
    logic                tms_s1_ff;
    logic                tms_ff;
    psbac_tap_type       tap_ff;
    psbac_tap_type       nxt_tap;
    logic                qual;
    logic                sel;
    logic                load;
    logic                push;
    logic                fifo_in_ready;
    logic                head_valid;
    psbac_wr_type        head;
    psbac_wr_type        commit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // Pin decode
    // A full commit queue also suspends the edge, so no write is lost
    assign qual = !clock_qualify_n && fifo_in_ready;
    assign sel  = !chip_select_1_n && chip_select_2 && !chip_select_3_n && !sleep_ff;
    assign load = !burst_step_or_load;

    function automatic logic [BURST_W-1:0] burst_low(
        input logic               inter,
        input logic [BURST_W-1:0] base,
        input logic [BURST_W-1:0] step
    );
        burst_low = inter ? (base ^ step) : (base + step);
    endfunction : burst_low

    // ==========================================================
    // Access start and burst counter
    always_comb begin
        nxt_op    = op_ff;
        nxt_start = start_ff;
        nxt_cnt   = cnt_ff;
        nxt_dir   = dir_ff;
        nxt_act   = act_ff;
        if (load) begin
            nxt_act          = sel;
            nxt_dir          = !write_n;
            nxt_start        = addr;
            nxt_cnt          = CNT_RST;
            nxt_op.valid     = sel;
            nxt_op.wr        = !write_n;
            nxt_op.addr      = addr;
            nxt_op.mask_n    = byte_lane_mask_n;
        end else begin
            // Selects and strobe are ignored while advancing
            nxt_cnt          = cnt_ff + CNT_STEP;
            nxt_act          = act_ff && !sleep_ff;
            nxt_op.valid     = nxt_act;
            nxt_op.wr        = dir_ff;
            nxt_op.addr      = {start_ff[ADDR_W-1:BURST_W], burst_low(mode_ff, start_ff[BURST_W-1:0], nxt_cnt)};
            nxt_op.mask_n    = byte_lane_mask_n;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            op_ff    <= OP_RST;
            start_ff <= ADDR_RST;
            cnt_ff   <= CNT_RST;
            dir_ff   <= 1'b0;
            act_ff   <= 1'b0;
        end else if (qual) begin
            op_ff    <= nxt_op;
            start_ff <= nxt_start;
            cnt_ff   <= nxt_cnt;
            dir_ff   <= nxt_dir;
            act_ff   <= nxt_act;
        end
    end

    // ==========================================================
    // Second pipeline stage: write data phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s2_ff <= OP_RST;
        end else if (qual) begin
            s2_ff <= op_ff;
        end
    end

    assign push        = qual && s2_ff.valid && s2_ff.wr;
    assign commit.addr   = s2_ff.addr;
    assign commit.mask_n = s2_ff.mask_n;
    assign commit.data   = dq_in;

    psbac_fifo #(
        .WIDTH ($bits(psbac_wr_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_commit_q (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (commit),
        .out_valid (head_valid),
        .out_ready (!sleep_ff),
        .out_data  (head)
    );

    // ==========================================================
    // Array, one memory per byte lane
    // The queue head is forwarded so a read two beats after a write sees it;
    // only the head is checked, deeper entries exist only after a sleep stall
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] lane_mem_ff [2**ADDR_W];
        logic              hit;

        always_ff @(posedge clk) begin
            if (head_valid && !sleep_ff && !head.mask_n[g]) begin
                lane_mem_ff[head.addr] <= head.data[g*LANE_W +: LANE_W];
            end
        end

        assign hit = head_valid && !head.mask_n[g] && (head.addr == op_ff.addr);
        assign rd_word[g*LANE_W +: LANE_W] = hit ? head.data[g*LANE_W +: LANE_W]
                                                 : lane_mem_ff[op_ff.addr];
    end

    // ==========================================================
    // Output register and drive state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dq_out_ff  <= DQ_RST;
            drive_n_ff <= DRIVE_OFF;
        end else if (qual) begin
            if (op_ff.valid && !op_ff.wr) begin
                dq_out_ff  <= rd_word;
                drive_n_ff <= 1'b0;
            end else begin
                drive_n_ff <= DRIVE_OFF;
            end
        end
    end

    assign dq_out  = dq_out_ff;
    // Output enable is asynchronous by nature, so it gates the drive directly
    assign dq_oe_n = drive_n_ff | output_enable_n;

    // ==========================================================
    // Sleep and strap synchronisers
    // Two stages give the two-cycle entry and exit; the array stops
    // taking writes while asleep and stored data stays put
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleep_s1_ff <= 1'b0;
            sleep_ff    <= 1'b0;
        end else begin
            sleep_s1_ff <= sleep_request;
            sleep_ff    <= sleep_s1_ff;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_s1_ff <= 1'b0;
            mode_ff    <= 1'b0;
        end else begin
            mode_s1_ff <= burst_mode;
            mode_ff    <= mode_s1_ff;
        end
    end

    assign sleep_active = sleep_ff;

    // ==========================================================
    // Test access port, stepped on sampled test clock rises
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tck_s1_ff <= 1'b0;
            tck_s2_ff <= 1'b0;
            tck_s3_ff <= 1'b0;
            tms_s1_ff <= 1'b1;
            tms_ff    <= 1'b1;
        end else begin
            tck_s1_ff <= test_clk;
            tck_s2_ff <= tck_s1_ff;
            tck_s3_ff <= tck_s2_ff;
            tms_s1_ff <= test_mode_select;
            tms_ff    <= tms_s1_ff;
        end
    end

    always_comb begin
        nxt_tap = tap_ff;
        unique case (tap_ff)
            TAP_RESET:  nxt_tap = tms_ff ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   nxt_tap = tms_ff ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: nxt_tap = tms_ff ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: nxt_tap = tms_ff ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  nxt_tap = tms_ff ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: nxt_tap = tms_ff ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: nxt_tap = tms_ff ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: nxt_tap = tms_ff ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: nxt_tap = tms_ff ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: nxt_tap = tms_ff ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: nxt_tap = tms_ff ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  nxt_tap = tms_ff ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: nxt_tap = tms_ff ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: nxt_tap = tms_ff ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: nxt_tap = tms_ff ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: nxt_tap = tms_ff ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tap_ff <= TAP_RESET;
        end else if (tck_s2_ff && !tck_s3_ff) begin
            tap_ff <= nxt_tap;
        end
    end

    assign tap_state = tap_ff;

    // ==========================================================
    // Checks
    a_freeze_hold: assert property (clock_qualify_n |=> $stable(op_ff) && $stable(cnt_ff)
        && $stable(dq_out_ff) && $stable(drive_n_ff)) else $error("state moved on unqualified edge");

    a_read_start: assert property (qual && sel && load && write_n |=> op_ff.valid && !op_ff.wr
        && op_ff.addr == $past(addr)) else $error("read not started");

    a_read_drive: assert property (qual && op_ff.valid && !op_ff.wr |=> !drive_n_ff
        && dq_out == $past(rd_word)) else $error("read data not registered out");

    a_write_tristate: assert property (qual && op_ff.valid && op_ff.wr |=> dq_oe_n)
        else $error("driving during write data phase");

    a_deselect_late: assert property (qual && load && !sel ##1 qual |=> dq_oe_n)
        else $error("outputs not off after deselect");

    a_burst_count: assert property (qual && !load |=> cnt_ff == $past(cnt_ff) + CNT_STEP)
        else $error("burst counter did not step");

    a_linear_step: assert property (qual && !load && !mode_ff |=>
        op_ff.addr[1:0] == $past(start_ff[1:0]) + $past(cnt_ff) + CNT_STEP) else $error("linear order wrong");

    a_inter_step: assert property (qual && !load && mode_ff |=>
        op_ff.addr[1:0] == ($past(start_ff[1:0]) ^ ($past(cnt_ff) + CNT_STEP))) else $error("interleave wrong");

    a_dir_kept: assert property (qual && !load |=> op_ff.wr == $past(dir_ff))
        else $error("burst direction changed");

    a_write_commit: assert property (qual && op_ff.valid && op_ff.wr ##1 qual[*1] ##0 1'b1 |-> push)
        else $error("write data not captured");

endmodule : psbac_core

// >>> psbac_core_tb.sv
// Purpose: Self-checking bench for the pipelined burst SRAM access control
// Assumes: Controller model drives the pins on the falling edge
// Notes:   Reads never follow a write to the same word within three beats
`timescale 1ns/10ps

module psbac_core_tb import psbac_pkg::*; ;
    logic              clk;
    logic              nrst;
    logic              clock_qualify_n;
    logic [2:0]        cs;
    logic              burst_step_or_load;
    logic              write_n;
    logic [LANES-1:0]  byte_lane_mask_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
    logic              output_enable_n;
    logic              sleep_request;
    logic              burst_mode;
    logic              sleep_active;
    logic              test_clk;
    logic              test_mode_select;
    psbac_tap_type     tap_state;
    int                error_cnt;
    int                num_checks;
    int                g;
    logic [DATA_W-1:0] mem [256];
    logic              act, bwr, rd_v, e_rd, w1_v, w2_v, pre_oe;
    logic [ADDR_W-1:0] base, rd_a, e_a, w1_a, w2_a;
    logic [LANES-1:0]  w1_m, w2_m;
    logic [1:0]        cnt;
    logic [DATA_W-1:0] pre_q;
    // Walk covers both pause loops and the whole instruction column
    logic [29:0]       tms_seq = 30'h3e9a_af56;
    psbac_tap_type     tap_exp [30] = '{TAP_RESET, TAP_RESET, TAP_RESET, TAP_RESET, TAP_RESET, TAP_IDLE,
                                        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_UPD_DR, TAP_IDLE,
                                        TAP_SEL_DR, TAP_CAP_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_SH_DR,
                                        TAP_EX1_DR, TAP_UPD_DR, TAP_SEL_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_EX1_IR,
                                        TAP_PAU_IR, TAP_EX2_IR, TAP_SH_IR, TAP_EX1_IR, TAP_UPD_IR, TAP_IDLE};

    psbac_core i_psbac_core (.clk(clk), .nrst(nrst), .clock_qualify_n(clock_qualify_n),
        .chip_select_1_n(cs[2]), .chip_select_2(cs[1]), .chip_select_3_n(cs[0]),
        .burst_step_or_load(burst_step_or_load), .write_n(write_n), .byte_lane_mask_n(byte_lane_mask_n),
        .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .output_enable_n(output_enable_n),
        .sleep_request(sleep_request), .burst_mode(burst_mode), .sleep_active(sleep_active),
        .test_clk(test_clk), .test_mode_select(test_mode_select), .tap_state(tap_state));

    psbac_ctrl_model i_psbac_ctrl_model (.clk(clk), .clock_qualify_n(clock_qualify_n), .cs_pins(cs),
        .burst_step_or_load(burst_step_or_load), .write_n(write_n), .byte_lane_mask_n(byte_lane_mask_n),
        .addr(addr), .dq_in(dq_in), .output_enable_n(output_enable_n), .sleep_request(sleep_request));

    initial begin
        clk = 1'b0;
    end

    always #4 clk = ~clk;

    // ==========================================================
    // Compare and expectation helpers
    task automatic cmp_data(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s: expected %h seen %h", what, e, s);
        end
    endtask : cmp_data

    task automatic cmp_bit(input string what, input logic e, input logic s);
        cmp_data(what, {35'h0_0000_0000, e}, {35'h0_0000_0000, s});
    endtask : cmp_bit

    task automatic cmp_tap(input string what, input psbac_tap_type e, input psbac_tap_type s);
        cmp_data(what, {32'h0000_0000, e}, {32'h0000_0000, s});
    endtask : cmp_tap

    function automatic logic [ADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] b, input logic [1:0] n,
                                                    input logic il);
        beat_addr      = b;
        beat_addr[1:0] = il ? (b[1:0] ^ n) : (b[1:0] + n);
    endfunction : beat_addr

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // ==========================================================
    // Reference pipeline, checked at every rising edge
    always @(posedge clk) begin
        if (!nrst) begin
            {act, rd_v, w1_v, w2_v} = 4'h0;
        end else if (clock_qualify_n) begin
            pre_q  = dq_out;
            pre_oe = dq_oe_n;
            #1;
            cmp_data("held data", pre_q, dq_out);
            cmp_bit("held drive", pre_oe, dq_oe_n);
        end else begin
            for (g = 0; g < LANES; g++) begin
                if (w2_v && !w2_m[g]) mem[w2_a][g*LANE_W +: LANE_W] = dq_in[g*LANE_W +: LANE_W];
            end
            {w2_v, w2_a, w2_m} = {w1_v, w1_a, w1_m};
            if (!burst_step_or_load) begin
                act  = cs == 3'h2;
                bwr  = !write_n;
                base = addr;
                cnt  = 2'h0;
            end else begin
                cnt = cnt + 2'h1;
            end
            e_rd = rd_v;
            e_a  = rd_a;
            rd_v = act && !bwr;
            rd_a = beat_addr(base, cnt, burst_mode);
            {w1_v, w1_a, w1_m} = {act && bwr, rd_a, byte_lane_mask_n};
            #1;
            if (e_rd) begin
                cmp_bit("read drive", output_enable_n, dq_oe_n);
                if (!output_enable_n) cmp_data("read data", mem[e_a], dq_out);
            end else begin
                cmp_bit("released drive", 1'b1, dq_oe_n);
            end
        end
    end

    // ==========================================================
    // Stimulus
    task automatic burst(input logic wr, input logic [ADDR_W-1:0] a, input int len, input int stall,
                         input logic [LANES-1:0] keep);
        logic [63:0] r;
        int          k;
        for (k = 0; k < len; k++) begin
            r = {$urandom, $urandom};
            while ($urandom % 100 < stall) begin
                i_psbac_ctrl_model.beat(1'b1, r[0], r[3:1], r[4], r[12:5], r[16:13], r[52:17], 1'b0);
            end
            if (k == 0) i_psbac_ctrl_model.beat(1'b0, 1'b0, 3'h2, !wr, a, r[16:13] & keep, r[52:17], &r[62:60]);
            else i_psbac_ctrl_model.beat(1'b0, 1'b1, r[3:1], r[4], r[12:5], r[16:13] & keep, r[52:17],
                                         &r[62:60]);
        end
    endtask : burst

    task automatic idle(input int n);
        int sh;
        repeat (n) begin
            sh = $urandom % 3;
            i_psbac_ctrl_model.beat(1'b0, 1'b0, 3'h2 ^ (3'h1 << sh), 1'b1, ADDR_RST, MASK_RST, DQ_RST,
                                    1'b0);
        end
    endtask : idle

    task automatic tck(input logic tms);
        test_mode_select = tms;
        repeat (4) @(negedge clk);
        test_clk = 1'b1;
        repeat (8) @(negedge clk);
        test_clk = 1'b0;
        repeat (4) @(negedge clk);
    endtask : tck

    initial begin
        #500_000;
        error_cnt++;
        summarize();
    end

    initial begin
        void'($urandom(22));
        {nrst, burst_mode, test_clk, test_mode_select} = 4'h1;
        error_cnt  = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        #1;
        cmp_data("reset data", DQ_RST, dq_out);
        cmp_bit("reset drive", DRIVE_OFF, dq_oe_n);
        cmp_tap("reset tap", TAP_RESET, tap_state);
        @(negedge clk);
        nrst = 1'b1;
        idle(4);
        cmp_bit("sleep flag", 1'b0, sleep_active);
        $display("test reset done");
        for (int i = 0; i < 64; i++) burst(1'b1, 8'(i * 4), 4, 0, 4'h0);
        idle(3);
        $display("test fill done");
        burst_mode = 1'b1;
        idle(4);
        for (int i = 0; i < 64; i++) burst(1'b0, 8'(i * 5), 4, 20, 4'hf);
        idle(3);
        $display("test readback done");
        for (int m = 0; m < 2; m++) begin
            burst_mode = m[0];
            idle(4);
            repeat (40) begin
                burst(1'b0, 8'($urandom), 1 + $urandom % 4, 20, 4'hf);
                burst(1'b0, 8'($urandom), 1 + $urandom % 4, 20, 4'hf);
                burst(1'b1, 8'($urandom), 1 + $urandom % 4, 20, 4'hf);
                idle(3);
            end
            $display("test random mode %0d done", m);
        end
        for (int i = 0; i < 30; i++) begin
            tck(tms_seq[29 - i]);
            cmp_tap("tap state", tap_exp[i], tap_state);
        end
        $display("test tap done");
        summarize();
    end
endmodule : psbac_core_tb

// >>> psbac_ctrl_model.sv
// Purpose: Memory controller model driving the SRAM pins
// Assumes: Pins change on the falling clock edge only
// Notes:   Idle data lines toggle so a stale value never passes for data
`timescale 1ns/10ps

module psbac_ctrl_model import psbac_pkg::*; (
    // Clock
    input  wire logic         clk,
    // Device pins
    output logic              clock_qualify_n,
    output logic [2:0]        cs_pins,
    output logic              burst_step_or_load,
    output logic              write_n,
    output logic [LANES-1:0]  byte_lane_mask_n,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] dq_in,
    output logic              output_enable_n,
    output logic              sleep_request
);
    logic              wr_burst;
    logic              cur_w;
    logic [DATA_W-1:0] cur_d;
    logic              p1_v_ff;
    logic              p2_v_ff;
    logic [DATA_W-1:0] p1_d_ff;
    logic [DATA_W-1:0] p2_d_ff;

    initial begin
        {wr_burst, cur_w, p1_v_ff, p2_v_ff} = 4'h0;
        {clock_qualify_n, burst_step_or_load, write_n, output_enable_n} = 4'h2;
        cs_pins          = 3'h6;
        byte_lane_mask_n = MASK_RST;
        addr             = ADDR_RST;
        dq_in            = DQ_RST;
        sleep_request    = 1'b0;
    end

    // One pin beat; the write flag is tracked only on qualified beats
    task automatic beat(input logic qn, input logic step, input logic [2:0] cs, input logic wn,
                        input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m, input logic [DATA_W-1:0] d,
                        input logic oe);
        @(negedge clk);
        clock_qualify_n    = qn;
        cs_pins            = cs;
        burst_step_or_load = step;
        write_n            = wn;
        addr               = a;
        byte_lane_mask_n   = m;
        output_enable_n    = oe;
        if (!qn && !step) wr_burst = (cs == 3'h2) && !wn;
        if (!qn) cur_w = wr_burst;
        if (!qn) cur_d = d;
    endtask : beat

    // ==========================================================
    // Write data two qualified rises behind its beat
    always @(posedge clk) begin
        if (!clock_qualify_n) begin
            p1_v_ff <= cur_w;
            p1_d_ff <= cur_d;
            p2_v_ff <= p1_v_ff;
            p2_d_ff <= p1_d_ff;
        end
    end

    always @(negedge clk) begin
        dq_in <= p2_v_ff ? p2_d_ff : ~dq_in;
    end
endmodule : psbac_ctrl_model

// >>> psbac_fifo.sv
// Purpose: Write commit queue between the pin pipeline and the array
// Assumes: Same clock as the core
// Notes:   Full drops in_ready so the source must stall
`timescale 1ns/10ps

module psbac_fifo import psbac_pkg::*; #(
    parameter int WIDTH = 48,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = count_ff != (PW+1)'(DEPTH);
    assign out_valid = count_ff != '0;
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule : psbac_fifo

// >>> psbac_pkg.sv
// Purpose: Shared constants and types for the pipelined burst SRAM access control
// Assumes: One 125 MHz clock, asynchronous active-low reset
// Notes:   Each byte lane carries eight data bits plus its parity pin in bit 8

package psbac_pkg;

    // ==========================================================
    // Sizes
    localparam int ADDR_W     = 8;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;
    localparam int DATA_W     = LANES * LANE_W;
    localparam int BURST_W    = 2;
    localparam int FIFO_DEPTH = 32;

    // ==========================================================
    // Values after reset
    localparam logic [DATA_W-1:0]  DQ_RST    = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 8'h00;
    localparam logic [BURST_W-1:0] CNT_RST   = 2'h0;
    localparam logic [BURST_W-1:0] CNT_STEP  = 2'h1;
    localparam logic [LANES-1:0]   MASK_RST  = 4'hf;
    localparam logic               DRIVE_OFF = 1'b1;

    // ==========================================================
    // Test access port states
    typedef enum logic [3:0] {
        TAP_RESET   = 4'b0000,
        TAP_IDLE    = 4'b0001,
        TAP_SEL_DR  = 4'b0010,
        TAP_CAP_DR  = 4'b0011,
        TAP_SH_DR   = 4'b0100,
        TAP_EX1_DR  = 4'b0101,
        TAP_PAU_DR  = 4'b0110,
        TAP_EX2_DR  = 4'b0111,
        TAP_UPD_DR  = 4'b1000,
        TAP_SEL_IR  = 4'b1001,
        TAP_CAP_IR  = 4'b1010,
        TAP_SH_IR   = 4'b1011,
        TAP_EX1_IR  = 4'b1100,
        TAP_PAU_IR  = 4'b1101,
        TAP_EX2_IR  = 4'b1110,
        TAP_UPD_IR  = 4'b1111
    } psbac_tap_type;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic              valid;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  mask_n;
    } psbac_op_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  mask_n;
        logic [DATA_W-1:0] data;
    } psbac_wr_type;

    localparam psbac_op_type OP_RST = '{1'b0, 1'b0, ADDR_RST, MASK_RST};

endpackage : psbac_pkg
